// File: shared/ecr_pkg.sv
`default_nettype none
package ecr_pkg;
    // Register indices (8-bit privileged register index)
    localparam logic [7:0] IDX_CYCLE_COUNTER = 8'hc0;
    localparam logic [7:0] IDX_CYCLE_COUNTER_CONTROL = 8'hc1;
    localparam logic [7:0] IDX_FAULT_ADDRESS = 8'hc2;
    localparam logic [7:0] IDX_FORMATTED_PTE_ADDRESS = 8'hc3;
    localparam logic [7:0] IDX_ADDRESS_CONTROL = 8'hc4;
    // Field positions
    localparam int CTL_ENABLE_BIT = 32;
    localparam int CTL_COUNT_HI = 31;
    localparam int CTL_COUNT_LO = 4;
    localparam int ACTL_ALT_FORMAT_BIT = 2;
    localparam int ACTL_WIDE_BIT = 1;
    localparam int ACTL_BIG_ENDIAN_BIT = 0;
    localparam int PTB_LO = 30;
    localparam int NARROW_SIGN_BIT = 42;
    localparam int WIDE_SIGN_BIT = 47;
    localparam int VPN_LO = 13;
    // Reset values
    localparam logic [63:0] COUNTER_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;
    localparam logic [33:0] PTB_RESET = 34'h0_0000_0000;
    // Data-stream access sizes
    typedef enum logic [1:0] {
        ECR_SIZE_BYTE = 2'b00,
        ECR_SIZE_WORD = 2'b01,
        ECR_SIZE_LONG = 2'b10,
        ECR_SIZE_QUAD = 2'b11
    } ecr_size_t;
endpackage
`default_nettype wire

// File: design/ecr_sign_check.sv
`default_nettype none
module ecr_sign_check
    import ecr_pkg::*;
(
    // Address and mode
    input wire logic [63:0] eff_addr,
    input wire logic wide_address_select,
    // Result
    output logic translation_violation
);
    logic narrow_bad;
    logic wide_bad;

    assign narrow_bad = eff_addr != {{21{eff_addr[NARROW_SIGN_BIT]}}, eff_addr[42:0]}; // [R10]
    assign wide_bad = eff_addr != {{16{eff_addr[WIDE_SIGN_BIT]}}, eff_addr[47:0]}; // [R9]
    assign translation_violation = wide_address_select ? wide_bad : narrow_bad; // [R8]
endmodule // ecr_sign_check
`default_nettype wire

// File: design/ecr_formatter.sv
`default_nettype none
module ecr_formatter
    import ecr_pkg::*;
(
    // Sources
    input wire logic [63:0] fault_address,
    input wire logic [33:0] page_table_base,
    input wire logic wide_address_select,
    input wire logic alt_format_select,
    // Result
    output logic [63:0] formatted
);
    always_comb
    begin
        // Narrow width: base in 63:33, VPN 42:13 in 32:3
        // Wide width: base in 63:43 sign-filled by VPN top, VPN 47:13 in 37:3
        // Alternate: 32-bit layout, base low bits 31:30, VPN 31:13 in 21:3
        if (alt_format_select) // [R13]
        begin
            formatted = {{32{page_table_base[1]}}, page_table_base[1:0],
                8'h00, fault_address[31:VPN_LO], 3'b000}; // [R16]
        end
        else if (wide_address_select) // [R8]
        begin
            formatted = {page_table_base[33:13], {5{fault_address[47]}},
                fault_address[47:VPN_LO], 3'b000}; // [R16]
        end
        else
        begin
            formatted = {page_table_base[33:3], fault_address[42:VPN_LO], 3'b000}; // [R14] [R16]
        end
    end
endmodule // ecr_formatter
`default_nettype wire

// File: design/ecr_unit.sv
// Contract
// [R1] Counter enable set: lower 32-bit half advances every clock.
// [R2] Write to counter loads upper half only; lower half keeps counting.
// [R3] Counter read returns upper and lower halves as one 64-bit value.
// [R4] Control write sets counter enable from written bit 32.
// [R5] Control write loads count bits 31:4 and clears bits 3:0.
// [R6] Translation miss or fault captures the effective address.
// [R7] No capture when the faulting access is a page-entry load.
// [R8] Address control bit 1 picks 43 or 48 bit width; resets zero.
// [R9] Wide mode: violation when address is not sign extension of 47:0.
// [R10] Narrow mode: violation when address is not sign extension of 42:0.
// [R11] Big-endian bit 0 inverts the three-bit shift amount.
// [R12] Big-endian inverts physical low bits by access size.
// [R13] Address control bit 2 selects alternate 32-bit formatted layout.
// [R14] Formatted register built from fault address and base bits 63:30.
// [R15] Lower counter half wraps without carry into the upper half.
// [R16] Formatted address: base on top, page number below, bits 2:0 zero.
`default_nettype none
module ecr_unit
    import ecr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Privileged register moves
    input wire logic privileged_register_write,
    input wire logic privileged_register_read,
    input wire logic [7:0] reg_index,
    input wire logic [63:0] write_data,
    output logic [63:0] read_data,
    output logic read_valid,
    // Read cycle counter instruction
    output logic [63:0] cycle_counter_value,
    // Memory pipe events
    input wire logic data_translation_miss,
    input wire logic data_stream_fault,
    input wire logic page_entry_load_instr,
    input wire logic [63:0] eff_addr,
    output logic translation_violation,
    // Byte manipulation and data-stream lanes
    input wire logic [2:0] shift_amount,
    output logic [2:0] shift_amount_eff,
    input wire logic [2:0] phys_addr_low,
    input wire ecr_size_t access_size,
    output logic [2:0] phys_addr_low_eff
);
    logic [63:0] cycle_counter;
    logic [31:0] count_upper;
    logic [31:0] count_lower;
    logic counter_enable_bit;
    logic [63:0] fault_address;
    logic [33:0] page_table_base;
    logic alt_format_select;
    logic wide_address_select;
    logic big_endian;
    logic [63:0] formatted_pte_address;
    logic wr_cc;
    logic wr_ctl;
    logic wr_actl;
    logic capture;

    assign wr_cc = privileged_register_write && reg_index == IDX_CYCLE_COUNTER;
    assign wr_ctl = privileged_register_write && reg_index == IDX_CYCLE_COUNTER_CONTROL;
    assign wr_actl = privileged_register_write && reg_index == IDX_ADDRESS_CONTROL;
    assign capture = (data_translation_miss || data_stream_fault)
        && !page_entry_load_instr; // [R6] [R7]

    // Halves kept in separate registers so each has a single writer
    assign cycle_counter = {count_upper, count_lower}; // [R3]

    // Upper half: storage only
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            count_upper <= COUNTER_RESET[63:32];
        else if (wr_cc)
            count_upper <= write_data[63:32]; // [R2]
    end

    // Lower half: counting; a control write takes priority over the increment
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            count_lower <= COUNTER_RESET[31:0];
        else if (wr_ctl)
            count_lower <= {write_data[CTL_COUNT_HI:CTL_COUNT_LO], 4'h0}; // [R5]
        else if (counter_enable_bit)
            count_lower <= count_lower + 32'h1; // [R1] [R15]
    end

    chk_count_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
        !counter_enable_bit && !wr_ctl |=> $stable(count_lower))
        else $error("lower counter moved while disabled");
    // Wrap must not ripple into the offset half
    chk_count_wrap: assert property (@(posedge ref_clk) disable iff (!resetn) // [R15]
        counter_enable_bit && !wr_ctl && !wr_cc && count_lower == 32'hffff_ffff
            |=> count_lower == 32'h0 && $stable(count_upper))
        else $error("lower counter wrap wrong");

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            counter_enable_bit <= 1'b0;
        else if (wr_ctl)
            counter_enable_bit <= write_data[CTL_ENABLE_BIT]; // [R4]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            fault_address <= ADDR_RESET;
        else if (capture)
            fault_address <= eff_addr; // [R6] [R7]
    end

    chk_stream_fault: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
        data_stream_fault && !page_entry_load_instr |=> fault_address == $past(eff_addr))
        else $error("fault address not captured on stream fault");
    chk_fault_idle: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
        !data_translation_miss && !data_stream_fault |=> $stable(fault_address))
        else $error("fault address changed without event");

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            page_table_base <= PTB_RESET;
            alt_format_select <= 1'b0;
            wide_address_select <= 1'b0;
            big_endian <= 1'b0;
        end
        else if (wr_actl)
        begin
            page_table_base <= write_data[63:PTB_LO]; // [R14]
            alt_format_select <= write_data[ACTL_ALT_FORMAT_BIT]; // [R13]
            wide_address_select <= write_data[ACTL_WIDE_BIT]; // [R8]
            big_endian <= write_data[ACTL_BIG_ENDIAN_BIT]; // [R11]
        end
    end

    chk_ctl_fields: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8] [R13]
        wr_actl |=> page_table_base == $past(write_data[63:PTB_LO])
            && alt_format_select == $past(write_data[ACTL_ALT_FORMAT_BIT])
            && wide_address_select == $past(write_data[ACTL_WIDE_BIT])
            && big_endian == $past(write_data[ACTL_BIG_ENDIAN_BIT]))
        else $error("address control fields not taken");

    ecr_formatter u_formatter (
        .fault_address(fault_address),
        .page_table_base(page_table_base),
        .wide_address_select(wide_address_select),
        .alt_format_select(alt_format_select),
        .formatted(formatted_pte_address)
    );

    chk_format_base: assert property (@(posedge ref_clk) disable iff (!resetn) // [R14] [R16]
        !alt_format_select && !wide_address_select |-> formatted_pte_address[63:33]
            == page_table_base[33:3] && formatted_pte_address[32:3] == fault_address[42:13])
        else $error("narrow formatted layout wrong");
    chk_format_wide: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8] [R16]
        wide_address_select && !alt_format_select |-> formatted_pte_address[63:43]
            == page_table_base[33:13] && formatted_pte_address[37:3] == fault_address[47:13])
        else $error("wide formatted layout wrong");
    chk_format_sign: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8] [R16]
        wide_address_select && !alt_format_select
            |-> formatted_pte_address[42:38] == {5{fault_address[47]}})
        else $error("wide formatted sign fill wrong");
    chk_format_alt: assert property (@(posedge ref_clk) disable iff (!resetn) // [R13]
        alt_format_select |-> formatted_pte_address[31:30] == page_table_base[1:0]
            && formatted_pte_address[21:3] == fault_address[31:13])
        else $error("alternate formatted layout wrong");

    ecr_sign_check u_sign (
        .eff_addr(eff_addr),
        .wide_address_select(wide_address_select),
        .translation_violation(translation_violation)
    );

    // Corner patterns: top bits clear, with the wide sign bit 47 set, with any of bits 46:43 set, or with all of 63:42 clear
    chk_wide_detect: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
        wide_address_select && eff_addr[63:47] == 17'h0_0001 |-> translation_violation)
        else $error("wide violation missed");
    chk_narrow_ok: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
        !wide_address_select && eff_addr[63:42] == 22'h0 |-> !translation_violation)
        else $error("false narrow violation");
    chk_width_select: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
        eff_addr[63:47] == 17'h0 && eff_addr[46:43] != 4'h0
            |-> translation_violation == !wide_address_select)
        else $error("width select not applied to sign check");

    assign cycle_counter_value = cycle_counter; // [R3]

    // Write-only registers read as zero
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            read_data <= 64'h0;
            read_valid <= 1'b0;
        end
        else
        begin
            read_valid <= privileged_register_read;
            if (privileged_register_read)
            begin
                case (reg_index)
                    IDX_CYCLE_COUNTER: read_data <= cycle_counter; // [R3]
                    IDX_FAULT_ADDRESS: read_data <= fault_address;
                    IDX_FORMATTED_PTE_ADDRESS: read_data <= formatted_pte_address; // [R14]
                    default: read_data <= 64'h0;
                endcase
            end
        end
    end

    chk_read_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
        !privileged_register_read |=> !read_valid)
        else $error("read valid without request");
    chk_read_fault: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
        privileged_register_read && reg_index == IDX_FAULT_ADDRESS
            |=> read_valid && read_data == $past(fault_address))
        else $error("fault address read wrong");
    chk_read_format: assert property (@(posedge ref_clk) disable iff (!resetn) // [R14] [R16]
        privileged_register_read && reg_index == IDX_FORMATTED_PTE_ADDRESS
            |=> read_data == $past(formatted_pte_address) && read_data[2:0] == 3'b000)
        else $error("formatted address read wrong");
    chk_read_wo: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
        privileged_register_read && (reg_index == IDX_CYCLE_COUNTER_CONTROL
            || reg_index == IDX_ADDRESS_CONTROL) |=> read_data == 64'h0)
        else $error("write-only register read not zero");

    assign shift_amount_eff = big_endian ? ~shift_amount : shift_amount; // [R11]

    chk_shift_invert: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
        big_endian |-> (shift_amount_eff ^ shift_amount) == 3'b111)
        else $error("shift amount not inverted");
    chk_shift_pass: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
        !big_endian |-> shift_amount_eff == shift_amount)
        else $error("shift amount altered in little endian");

    always_comb
    begin
        phys_addr_low_eff = phys_addr_low;
        if (big_endian)
        begin
            case (access_size) // [R12]
                ECR_SIZE_BYTE: phys_addr_low_eff = phys_addr_low ^ 3'b111;
                ECR_SIZE_WORD: phys_addr_low_eff = phys_addr_low ^ 3'b110;
                ECR_SIZE_LONG: phys_addr_low_eff = phys_addr_low ^ 3'b100;
                default: phys_addr_low_eff = phys_addr_low;
            endcase
        end
    end

    chk_endian_byte: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
        big_endian && access_size == ECR_SIZE_BYTE |-> phys_addr_low_eff == ~phys_addr_low)
        else $error("byte lane inversion wrong");
    chk_endian_word: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
        big_endian && access_size == ECR_SIZE_WORD
            |-> phys_addr_low_eff[2:1] == ~phys_addr_low[2:1] && phys_addr_low_eff[0] == phys_addr_low[0])
        else $error("word lane inversion wrong");
    // Quadword accesses and little-endian mode leave the lanes alone
    chk_plain_lanes: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
        !big_endian || access_size == ECR_SIZE_QUAD |-> phys_addr_low_eff == phys_addr_low)
        else $error("lanes altered without inversion");

    chk_count_advance: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1]
        counter_enable_bit && !wr_ctl |=> cycle_counter[31:0] == $past(cycle_counter[31:0]) + 32'h1)
        else $error("lower counter did not advance");
    chk_upper_load: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
        wr_cc && !wr_ctl && counter_enable_bit |=> cycle_counter[63:32] == $past(write_data[63:32])
            && cycle_counter[31:0] == $past(cycle_counter[31:0]) + 32'h1)
        else $error("upper load disturbed lower half");
    chk_ctl_load: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
        wr_ctl |=> cycle_counter[3:0] == 4'h0 && cycle_counter[31:4] == $past(write_data[31:4]))
        else $error("control write load wrong");
    chk_enable_set: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
        wr_ctl |=> counter_enable_bit == $past(write_data[CTL_ENABLE_BIT]))
        else $error("enable not taken");
    chk_no_carry: assert property (@(posedge ref_clk) disable iff (!resetn) // [R15]
        !wr_cc |=> cycle_counter[63:32] == $past(cycle_counter[63:32]))
        else $error("upper half changed without write");
    chk_fault_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R7]
        page_entry_load_instr |=> $stable(fault_address))
        else $error("fault address changed on page entry load");
    chk_fault_take: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
        data_translation_miss && !page_entry_load_instr |=> fault_address == $past(eff_addr))
        else $error("fault address not captured");
    chk_read_counter: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
        privileged_register_read && reg_index == IDX_CYCLE_COUNTER
            |=> read_valid && read_data == $past(cycle_counter))
        else $error("counter read wrong");
    chk_wide_viol: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
        wide_address_select && eff_addr[63:47] == 17'h0 |-> !translation_violation)
        else $error("false wide violation");
    chk_narrow_viol: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
        !wide_address_select && eff_addr[47:43] == 5'h1 && eff_addr[63:48] == 16'h0
            |-> translation_violation)
        else $error("narrow violation missed");
    chk_endian_lane: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
        big_endian && access_size == ECR_SIZE_LONG |-> phys_addr_low_eff[1:0] == phys_addr_low[1:0]
            && phys_addr_low_eff[2] != phys_addr_low[2])
        else $error("longword lane inversion wrong");
endmodule // ecr_unit
`default_nettype wire

// File: tb/ecr_pipe_model.sv
`default_nettype none
module ecr_pipe_model
    import ecr_pkg::*;
(
    // Clock and answer
    input wire logic ref_clk,
    input wire logic [63:0] read_data,
    input wire logic read_valid,
    // Register moves
    output logic privileged_register_write,
    output logic privileged_register_read,
    output logic [7:0] reg_index,
    output logic [63:0] write_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        privileged_register_write = 1'b0;
        privileged_register_read = 1'b0;
        reg_index = 8'h00;
        write_data = 64'h0;
    end
    // Released lines carry the inverse so a stale value cannot pass
    task automatic wr(input logic [7:0] idx, input logic [63:0] d);
        @(negedge ref_clk);
        privileged_register_write = 1'b1;
        reg_index = idx;
        write_data = d;
        @(negedge ref_clk);
        privileged_register_write = 1'b0;
        reg_index = ~idx;
        write_data = ~d;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [63:0] d, output logic ok);
        @(negedge ref_clk);
        privileged_register_read = 1'b1;
        reg_index = idx;
        @(negedge ref_clk);
        privileged_register_read = 1'b0;
        reg_index = ~idx;
        ok = read_valid;
        d = read_data;
    endtask
endmodule // ecr_pipe_model
`default_nettype wire

// File: tb/execution_unit_control_registers_bench.sv
`default_nettype none
module execution_unit_control_registers_bench
    import ecr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, resetn, wr_s, rd_s, ok, miss, fault, pel, viol, en, w, al;
    logic [7:0] idx;
    logic [63:0] wd, rdat, ccv, eff_addr, d, a;
    logic rvld;
    logic [2:0] sa, sa_eff, pa, pa_eff;
    ecr_size_t asz;
    logic [31:0] base, hi;
    logic [33:0] b;
    int err_total, num_checks, cyc, t0;
    logic [7:0] ri [6] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'h5a};
    logic [2:0] lm [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    ecr_unit i_dut (.ref_clk(ref_clk), .resetn(resetn), .privileged_register_write(wr_s),
        .privileged_register_read(rd_s), .reg_index(idx), .write_data(wd), .read_data(rdat),
        .read_valid(rvld), .cycle_counter_value(ccv), .data_translation_miss(miss),
        .data_stream_fault(fault), .page_entry_load_instr(pel), .eff_addr(eff_addr),
        .translation_violation(viol), .shift_amount(sa), .shift_amount_eff(sa_eff),
        .phys_addr_low(pa), .access_size(asz), .phys_addr_low_eff(pa_eff));
    ecr_pipe_model u_pipe (.ref_clk(ref_clk), .read_data(rdat), .read_valid(rvld),
        .privileged_register_write(wr_s), .privileged_register_read(rd_s),
        .reg_index(idx), .write_data(wd));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] lo(input int k);
        return en ? base + 32'(cyc - t0 - k) : base;
    endfunction
    function automatic logic bad(input logic [63:0] x, input logic wide);
        return wide ? x !== {{16{x[47]}}, x[47:0]} : x !== {{21{x[42]}}, x[42:0]};
    endfunction
    function automatic logic [63:0] fmt(input logic [63:0] x, input logic [33:0] pb,
        input logic wide, input logic alt);
        if (alt)
            return {{32{pb[1]}}, pb[1:0], 8'h00, x[31:13], 3'h0};
        return wide ? {pb[33:13], {5{x[47]}}, x[47:13], 3'h0} : {pb[33:3], x[42:13], 3'h0};
    endfunction
    task automatic ev(input logic [63:0] x, input logic f, input logic p, input logic wide);
        @(negedge ref_clk);
        eff_addr = x;
        miss = ~f;
        fault = f;
        pel = p;
        #1 chk("violation", {63'h0, viol}, {63'h0, bad(x, wide)});
        @(negedge ref_clk);
        miss = 1'b0;
        fault = 1'b0;
        pel = 1'b0;
        eff_addr = ~x;
    endtask
    initial
    begin
        {resetn, miss, fault, pel, en, cyc, t0, err_total, num_checks} = '0;
        {eff_addr, sa, pa, base} = '0;
        asz = ECR_SIZE_BYTE;
        void'($urandom(32'h8db6));
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        // Reset contents, write-only and unmapped reads
        foreach (ri[i])
        begin
            u_pipe.rd(ri[i], d, ok);
            chk("read_valid", {63'h0, ok}, 64'h1);
            chk("reset_read", d, 64'h0);
        end
        // Control resets to the narrow width, so bit 43 alone must trip the checker
        ev(64'h0000_0800_0000_0000, 1'b0, 1'b0, 1'b0);
        $display("test reset done");
        u_pipe.wr(IDX_CYCLE_COUNTER_CONTROL, {31'h0, 1'b1, 32'hffff_fffa});
        base = 32'hffff_fff0;
        en = 1'b1;
        t0 = cyc;
        hi = $urandom;
        u_pipe.wr(IDX_CYCLE_COUNTER, {hi, 32'h5});
        // Long enough to cross the lower-half wrap
        repeat (20) @(negedge ref_clk);
        chk("counter", ccv, {hi, lo(0)});
        u_pipe.rd(IDX_CYCLE_COUNTER, d, ok);
        chk("counter_read", d, {hi, lo(1)});
        u_pipe.wr(IDX_CYCLE_COUNTER_CONTROL, {31'h0, 1'b0, 32'h1234_567f});
        base = 32'h1234_5670;
        en = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk("counter_stop", ccv, {hi, base});
        $display("test counter done");
        for (int m = 0; m < 4; m++)
        begin
            w = m[0];
            al = m[1];
            b = 34'({$urandom, $urandom});
            b[0] = b[1];
            u_pipe.wr(IDX_ADDRESS_CONTROL, {b, 27'h0, al, w, 1'b0});
            ev(64'h0000_8800_0000_0000, 1'b0, 1'b0, w);
            repeat (6)
            begin
                a = {$urandom, $urandom};
                if ($urandom % 2)
                    a = w ? {{16{a[47]}}, a[47:0]} : {{21{a[42]}}, a[42:0]};
                ev(a, 1'($urandom), 1'b0, w);
                u_pipe.rd(IDX_FAULT_ADDRESS, d, ok);
                chk("fault_address", d, a);
                u_pipe.rd(IDX_FORMATTED_PTE_ADDRESS, d, ok);
                chk("formatted", d, fmt(a, b, w, al));
                ev(~a, 1'b1, 1'b1, w);
                u_pipe.wr(IDX_FAULT_ADDRESS, ~a);
                u_pipe.rd(IDX_FAULT_ADDRESS, d, ok);
                chk("fault_kept", d, a);
            end
        end
        $display("test address done");
        for (int e = 0; e < 2; e++)
        begin
            u_pipe.wr(IDX_ADDRESS_CONTROL, {63'h0, e[0]});
            for (int k = 0; k < 32; k++)
            begin
                @(negedge ref_clk);
                sa = 3'(k);
                pa = 3'(k + e);
                asz = ecr_size_t'(k >> 3);
                #1 chk("shift", {61'h0, sa_eff}, {61'h0, sa ^ {3{e[0]}}});
                chk("lanes", {61'h0, pa_eff}, {61'h0, pa ^ (lm[asz] & {3{e[0]}})});
            end
        end
        $display("test endian done");
        wrap_up();
    end
endmodule // execution_unit_control_registers_bench
`default_nettype wire
